// [logic/spseq_params.svh]
// Purpose: Constants of the stop/sleep power sequencer.
// Assumes: Included by the package and by every module of the block.
// Notes:   Timing counts are derived from the 200 MHz sequencer clock.
`ifndef SPSEQ_PARAMS_SVH
`define SPSEQ_PARAMS_SVH

// =====================================================================
// Widths
`define SPSEQ_TIMER_W 20
`define SPSEQ_FIELD_W 16
`define SPSEQ_NUM_WAKE_LINES 16
`define SPSEQ_NUM_BLOCK_CLOCKS 32
`define SPSEQ_BATTERY_FAULT_SLEEP_CONFIG_W 2

// =====================================================================
// Reset values and encodings
`define SPSEQ_XTAL_WAIT_RESET 16'h8000
`define SPSEQ_BATF_SLEEP_ENABLE 2'h1

// =====================================================================
// Timing
`define SPSEQ_CLOCK_MHZ 200
`define SPSEQ_OSC_SETTLE_US 1000
`define SPSEQ_OSC_SETTLE_CYCLES (`SPSEQ_OSC_SETTLE_US * `SPSEQ_CLOCK_MHZ)

`endif

// [logic/spseq_pkg.sv]
// Purpose: Types of the stop/sleep power sequencer.
// Assumes: Constants come from spseq_params.svh.
// Notes:   Nothing here is imported; users write spseq_pkg::name.
`include "spseq_params.svh"

package spseq_pkg;

    typedef logic [`SPSEQ_TIMER_W-1:0] spseq_count_t;

    typedef enum logic [3:0] {
        ST_RUN,
        ST_DRAIN,
        ST_SREF,
        ST_STOP_OFF,
        ST_STOP,
        ST_OSC_WAIT,
        ST_PLL_WAIT,
        ST_SLEEP,
        ST_PWR_WAIT,
        ST_RESTORE
    } spseq_state_e;

endpackage

// [logic/spseq_sync.sv]
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: Inputs are levels held well beyond two clock periods.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`include "spseq_params.svh"

module spseq_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // =====================================================================
    // One pair of flops per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic stage1_reg;
            logic stage2_reg;
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    stage1_reg <= 1'b0;
                    stage2_reg <= 1'b0;
                end else begin
                    stage1_reg <= async_in[i];
                    stage2_reg <= stage1_reg;
                end
            end
            assign sync_out[i] = stage2_reg;
        end
    endgenerate

endmodule

// [logic/spseq_timer.sv]
// Purpose: Loadable down-counter for the settle and lock waits.
// Assumes: Load value is at least one.
// Notes:   Done pulses one cycle, load_value edges after the edge that samples load.
`timescale 1ns/1ps
`include "spseq_params.svh"

module spseq_timer (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire spseq_pkg::spseq_count_t load_value,
    // Status
    output logic done
);

    // =====================================================================
    // Counter
    spseq_pkg::spseq_count_t count_reg;
    logic done_reg;
    wire last_tick = (count_reg == spseq_pkg::spseq_count_t'(1));

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
            done_reg <= 1'b0;
        end else if (load) begin
            count_reg <= load_value;
            done_reg <= 1'b0;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - spseq_pkg::spseq_count_t'(1);
            done_reg <= last_tick;
        end else begin
            done_reg <= 1'b0;
        end
    end

    assign done = done_reg;

endmodule

// [logic/spseq_sequencer.sv]
// Purpose: Entry into and exit from STOP and SLEEP power modes.
// Assumes: One clock, the reference clock; handshake partners share it.
// Notes:   Wake pins and the battery fault pin are synchronised here.
//
// Behaviour
// - Stop entry only on stop-request rising edge
// - Interrupt lines, alarm, tick, battery fault wake
// - Settle and lock waits inserted, clocks withheld
// - Entry first requests bus drain, awaits ack
// - Then self-refresh request, await memory ack
// - Stop: gate clocks, select reference clock
// - Stop last: PLLs off, oscillator off unless kept
// - Stop exit: enable oscillator when crystal in use, wait settle
// - Then reference clock, enable PLLs, wait lock
// - After lock select the PLL output again
// - Sleep by software or hardware, same handshakes
// - Sleep: oscillator, PLLs off, core power low
// - Sleep exit: core power high, programmable settle
// - Release system reset synchronously once power stable
// - After sleep PLLs off, reference clock
// - After stop restore PLL states and selection
// - Battery low blocks sleep exit when guarded
// - Battery fault enters sleep only when configured
// - Block clock enables reach the clock gates one cycle later
// - Lock wait counts reference cycles per PLL
// - Crystal settle count programmable, resets to 0x8000
`timescale 1ns/1ps
`include "spseq_params.svh"

module spseq_sequencer #(
    parameter int OSC_SETTLE_CYCLES = `SPSEQ_OSC_SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Software mode requests
    input wire logic stop_request,
    input wire logic sleep_request,
    // Configuration
    input wire logic keep_oscillator_in_stop,
    input wire logic sleep_exit_guard,
    input wire logic [`SPSEQ_BATTERY_FAULT_SLEEP_CONFIG_W-1:0] battery_fault_sleep_config,
    input wire logic crystal_in_use,
    input wire logic main_pll_on,
    input wire logic aux_pll_on,
    input wire logic pll_select,
    input wire logic [`SPSEQ_FIELD_W-1:0] main_pll_lock_count,
    input wire logic [`SPSEQ_FIELD_W-1:0] aux_pll_lock_count,
    input wire logic [`SPSEQ_FIELD_W-1:0] power_settle_count,
    input wire logic crystal_settle_write,
    input wire logic [`SPSEQ_FIELD_W-1:0] crystal_settle_count,
    input wire logic [`SPSEQ_NUM_BLOCK_CLOCKS-1:0] block_clock_enable,
    // Wake pins
    input wire logic [`SPSEQ_NUM_WAKE_LINES-1:0] external_interrupt_lines,
    input wire logic rtc_alarm,
    input wire logic rtc_tick,
    input wire logic battery_fault_input_n,
    // Bus controller handshake
    output logic bus_drain_req,
    input wire logic bus_drain_ack,
    // Memory controller handshake
    output logic self_refresh_req,
    input wire logic self_refresh_ack,
    // Clock and power control
    output logic system_clocks_on,
    output logic clock_select_pll,
    output logic main_pll_enable,
    output logic aux_pll_enable,
    output logic oscillator_enable,
    output logic core_power_enable,
    output logic system_reset,
    output logic [`SPSEQ_NUM_BLOCK_CLOCKS-1:0] block_clock_gate,
    // Status
    output logic sequencer_busy,
    output logic [3:0] wake_cause
);

    // =====================================================================
    // Pin synchronisation
    localparam int WAKE_W = `SPSEQ_NUM_WAKE_LINES + 3;
    logic [WAKE_W-1:0] wake_sync;
    spseq_sync #(.WIDTH(WAKE_W)) u_sync (
        .clock(clock),
        .reset(reset),
        .async_in({battery_fault_input_n, rtc_tick, rtc_alarm, external_interrupt_lines}),
        .sync_out(wake_sync)
    );
    wire external_interrupt_lines_any = |wake_sync[`SPSEQ_NUM_WAKE_LINES-1:0];
    wire alarm_s = wake_sync[`SPSEQ_NUM_WAKE_LINES];
    wire tick_s = wake_sync[`SPSEQ_NUM_WAKE_LINES+1];
    // Synchroniser resets low, so the fault reads as present until the pin is seen
    wire battery_low = ~wake_sync[`SPSEQ_NUM_WAKE_LINES+2];
    wire wake_any = external_interrupt_lines_any | alarm_s | tick_s | battery_low;
    wire [3:0] wake_now = {battery_low, tick_s, alarm_s, external_interrupt_lines_any};

    // =====================================================================
    // State
    spseq_pkg::spseq_state_e state_reg, state_next;
    logic mode_sleep_reg, mode_sleep_next, stop_prev_reg, sleep_prev_reg;
    logic [`SPSEQ_FIELD_W-1:0] crystal_settle_reg;
    logic timer_load_reg, timer_load_next, timer_done;
    spseq_pkg::spseq_count_t timer_value_reg, timer_value_next;
    logic bus_drain_req_reg, bus_drain_req_next, self_refresh_req_reg, self_refresh_req_next;
    logic clocks_on_reg, clocks_on_next, clock_select_pll_reg, clock_select_pll_next;
    logic main_pll_enable_reg, main_pll_enable_next, aux_pll_enable_reg, aux_pll_enable_next;
    logic oscillator_enable_reg, oscillator_enable_next, core_power_enable_reg, core_power_enable_next;
    logic system_reset_reg, system_reset_next, busy_reg, busy_next;
    logic [`SPSEQ_NUM_BLOCK_CLOCKS-1:0] block_clock_gate_reg;
    logic [3:0] wake_cause_reg, wake_cause_next;

    // =====================================================================
    // Triggers and wait lengths
    // A level left high starts nothing; software must drop it between entries
    wire stop_rise = stop_request & ~stop_prev_reg;
    wire sleep_rise = sleep_request & ~sleep_prev_reg;
    wire batf_sleep_allowed = (battery_fault_sleep_config == `SPSEQ_BATF_SLEEP_ENABLE);
    wire sleep_trigger = sleep_rise | (battery_low & batf_sleep_allowed);
    wire sleep_exit_ok = wake_any & ~(sleep_exit_guard & battery_low);
    wire [`SPSEQ_FIELD_W-1:0] crystal_settle_next = crystal_settle_write ? crystal_settle_count : crystal_settle_reg;
    wire spseq_pkg::spseq_count_t one_count = spseq_pkg::spseq_count_t'(1);
    wire spseq_pkg::spseq_count_t osc_floor = spseq_pkg::spseq_count_t'(OSC_SETTLE_CYCLES);
    wire spseq_pkg::spseq_count_t xtal_count = {4'h0, crystal_settle_reg};
    // Never shorter than the nominal settle time, whatever software programs
    wire spseq_pkg::spseq_count_t osc_wait = (xtal_count > osc_floor) ? xtal_count : osc_floor;
    wire osc_needs_settle = crystal_in_use & ~oscillator_enable_reg;
    wire spseq_pkg::spseq_count_t osc_load = osc_needs_settle ? osc_wait : one_count;
    wire spseq_pkg::spseq_count_t main_lock = main_pll_on ? {4'h0, main_pll_lock_count} : '0;
    wire spseq_pkg::spseq_count_t aux_lock = aux_pll_on ? {4'h0, aux_pll_lock_count} : '0;
    // The longer lock of the PLLs in use governs; both count reference cycles
    wire spseq_pkg::spseq_count_t lock_max = (main_lock > aux_lock) ? main_lock : aux_lock;
    wire spseq_pkg::spseq_count_t lock_load = (lock_max == '0) ? one_count : lock_max;
    wire spseq_pkg::spseq_count_t pwr_raw = {4'h0, power_settle_count};
    wire spseq_pkg::spseq_count_t pwr_load = (pwr_raw == '0) ? one_count : pwr_raw;

    // =====================================================================
    // Wait timer
    spseq_timer u_timer (.clock(clock), .reset(reset), .load(timer_load_reg),
        .load_value(timer_value_reg), .done(timer_done));

    // =====================================================================
    // Sequence
    always_comb begin
        state_next = state_reg;
        mode_sleep_next = mode_sleep_reg;
        timer_load_next = 1'b0;
        timer_value_next = timer_value_reg;
        bus_drain_req_next = bus_drain_req_reg;
        self_refresh_req_next = self_refresh_req_reg;
        clocks_on_next = clocks_on_reg;
        clock_select_pll_next = clock_select_pll_reg;
        main_pll_enable_next = main_pll_enable_reg;
        aux_pll_enable_next = aux_pll_enable_reg;
        oscillator_enable_next = oscillator_enable_reg;
        core_power_enable_next = core_power_enable_reg;
        system_reset_next = system_reset_reg;
        busy_next = 1'b1;
        wake_cause_next = wake_cause_reg;
        case (state_reg)
            spseq_pkg::ST_RUN: begin
                busy_next = 1'b0;
                main_pll_enable_next = main_pll_on;
                aux_pll_enable_next = aux_pll_on;
                clock_select_pll_next = pll_select;
                oscillator_enable_next = 1'b1;
                // Sleep wins a tie: a battery fault must not wait behind a stop
                if (sleep_trigger) begin
                    mode_sleep_next = 1'b1;
                    bus_drain_req_next = 1'b1;
                    busy_next = 1'b1;
                    state_next = spseq_pkg::ST_DRAIN;
                end else if (stop_rise) begin
                    mode_sleep_next = 1'b0;
                    bus_drain_req_next = 1'b1;
                    busy_next = 1'b1;
                    state_next = spseq_pkg::ST_DRAIN;
                end
            end
            spseq_pkg::ST_DRAIN: begin
                if (bus_drain_ack) begin
                    self_refresh_req_next = 1'b1;
                    state_next = spseq_pkg::ST_SREF;
                end
            end
            spseq_pkg::ST_SREF: begin
                if (self_refresh_ack) begin
                    clocks_on_next = 1'b0;
                    clock_select_pll_next = 1'b0;
                    if (mode_sleep_reg) begin
                        oscillator_enable_next = 1'b0;
                        main_pll_enable_next = 1'b0;
                        aux_pll_enable_next = 1'b0;
                        core_power_enable_next = 1'b0;
                        system_reset_next = 1'b1;
                        state_next = spseq_pkg::ST_SLEEP;
                    end else begin
                        state_next = spseq_pkg::ST_STOP_OFF;
                    end
                end
            end
            spseq_pkg::ST_STOP_OFF: begin
                main_pll_enable_next = 1'b0;
                aux_pll_enable_next = 1'b0;
                oscillator_enable_next = keep_oscillator_in_stop;
                state_next = spseq_pkg::ST_STOP;
            end
            spseq_pkg::ST_STOP: begin
                if (wake_any) begin
                    wake_cause_next = wake_now;
                    oscillator_enable_next = oscillator_enable_reg | crystal_in_use;
                    timer_load_next = 1'b1;
                    timer_value_next = osc_load;
                    state_next = spseq_pkg::ST_OSC_WAIT;
                end
            end
            spseq_pkg::ST_OSC_WAIT: begin
                if (timer_done) begin
                    clock_select_pll_next = 1'b0;
                    main_pll_enable_next = main_pll_on;
                    aux_pll_enable_next = aux_pll_on;
                    timer_load_next = 1'b1;
                    timer_value_next = lock_load;
                    state_next = spseq_pkg::ST_PLL_WAIT;
                end
            end
            spseq_pkg::ST_PLL_WAIT: begin
                if (timer_done) begin
                    clock_select_pll_next = pll_select;
                    clocks_on_next = 1'b1;
                    state_next = spseq_pkg::ST_RESTORE;
                end
            end
            spseq_pkg::ST_SLEEP: begin
                if (sleep_exit_ok) begin
                    wake_cause_next = wake_now;
                    core_power_enable_next = 1'b1;
                    timer_load_next = 1'b1;
                    timer_value_next = pwr_load;
                    state_next = spseq_pkg::ST_PWR_WAIT;
                end
            end
            spseq_pkg::ST_PWR_WAIT: begin
                if (timer_done) begin
                    system_reset_next = 1'b0;
                    clocks_on_next = 1'b1;
                    oscillator_enable_next = 1'b1;
                    main_pll_enable_next = 1'b0;
                    aux_pll_enable_next = 1'b0;
                    clock_select_pll_next = 1'b0;
                    state_next = spseq_pkg::ST_RESTORE;
                end
            end
            spseq_pkg::ST_RESTORE: begin
                self_refresh_req_next = 1'b0;
                bus_drain_req_next = 1'b0;
                state_next = spseq_pkg::ST_RUN;
            end
            default: begin
                state_next = spseq_pkg::ST_RUN;
            end
        endcase
    end

    // =====================================================================
    // Registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= spseq_pkg::ST_RUN;
            mode_sleep_reg <= 1'b0;
            stop_prev_reg <= 1'b0;
            sleep_prev_reg <= 1'b0;
            timer_load_reg <= 1'b0;
            timer_value_reg <= '0;
            wake_cause_reg <= 4'h0;
            busy_reg <= 1'b0;
            crystal_settle_reg <= `SPSEQ_XTAL_WAIT_RESET;
        end else begin
            state_reg <= state_next;
            mode_sleep_reg <= mode_sleep_next;
            stop_prev_reg <= stop_request;
            sleep_prev_reg <= sleep_request;
            timer_load_reg <= timer_load_next;
            timer_value_reg <= timer_value_next;
            wake_cause_reg <= wake_cause_next;
            busy_reg <= busy_next;
            crystal_settle_reg <= crystal_settle_next;
        end
    end

    // One cycle from a changed enable bit to the gate; all gated while clocks are withheld
    wire [`SPSEQ_NUM_BLOCK_CLOCKS-1:0] gate_next =
        block_clock_enable & {`SPSEQ_NUM_BLOCK_CLOCKS{clocks_on_reg}};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bus_drain_req_reg <= 1'b0;
            self_refresh_req_reg <= 1'b0;
            clocks_on_reg <= 1'b1;
            clock_select_pll_reg <= 1'b0;
            main_pll_enable_reg <= 1'b0;
            aux_pll_enable_reg <= 1'b0;
            oscillator_enable_reg <= 1'b1;
            core_power_enable_reg <= 1'b1;
            system_reset_reg <= 1'b0;
            block_clock_gate_reg <= '0;
        end else begin
            bus_drain_req_reg <= bus_drain_req_next;
            self_refresh_req_reg <= self_refresh_req_next;
            clocks_on_reg <= clocks_on_next;
            clock_select_pll_reg <= clock_select_pll_next;
            main_pll_enable_reg <= main_pll_enable_next;
            aux_pll_enable_reg <= aux_pll_enable_next;
            oscillator_enable_reg <= oscillator_enable_next;
            core_power_enable_reg <= core_power_enable_next;
            system_reset_reg <= system_reset_next;
            block_clock_gate_reg <= gate_next;
        end
    end

    // =====================================================================
    // Outputs
    assign bus_drain_req = bus_drain_req_reg;
    assign self_refresh_req = self_refresh_req_reg;
    assign system_clocks_on = clocks_on_reg;
    assign clock_select_pll = clock_select_pll_reg;
    assign main_pll_enable = main_pll_enable_reg;
    assign aux_pll_enable = aux_pll_enable_reg;
    assign oscillator_enable = oscillator_enable_reg;
    assign core_power_enable = core_power_enable_reg;
    assign system_reset = system_reset_reg;
    assign block_clock_gate = block_clock_gate_reg;
    assign sequencer_busy = busy_reg;
    assign wake_cause = wake_cause_reg;

endmodule

// [tb/spseq_sva.sv]
// Purpose: Port-level checks of the power sequencer.
// Assumes: Bound to spseq_sequencer, one clock.
// Notes: Watches outputs and the handshake, request, select and enable inputs.
`timescale 1ns/1ps
module spseq_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Inputs
    input wire logic stop_request,
    input wire logic pll_select,
    input wire logic bus_drain_ack,
    input wire logic self_refresh_ack,
    input wire logic [31:0] block_clock_enable,
    // Outputs
    input wire logic bus_drain_req,
    input wire logic self_refresh_req,
    input wire logic system_clocks_on,
    input wire logic clock_select_pll,
    input wire logic main_pll_enable,
    input wire logic aux_pll_enable,
    input wire logic oscillator_enable,
    input wire logic core_power_enable,
    input wire logic system_reset,
    input wire logic sequencer_busy,
    input wire logic [31:0] block_clock_gate
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    stop_start_a: assert property (!sequencer_busy && $past(!sequencer_busy) && $rose(stop_request) |=> bus_drain_req)
        else $error("stop edge ignored");
    drain_first_a: assert property ($rose(self_refresh_req) |-> bus_drain_req && $past(bus_drain_ack))
        else $error("refresh asked before drain ack");
    clock_off_a: assert property ($fell(system_clocks_on) |-> self_refresh_req && $past(self_refresh_ack) && !clock_select_pll)
        else $error("clocks gated without refresh ack");
    pll_off_a: assert property ($fell(system_clocks_on) |=> !main_pll_enable && !aux_pll_enable)
        else $error("PLLs left on");
    gate_follow_a: assert property (!$past(reset) |-> block_clock_gate ==
        $past(block_clock_enable & {32{system_clocks_on}}))
        else $error("block gate wrong");
    power_off_a: assert property ($fell(core_power_enable) |-> system_reset && !oscillator_enable && !system_clocks_on)
        else $error("core power dropped early");
    reset_drop_a: assert property ($fell(system_reset) |-> core_power_enable && system_clocks_on && !clock_select_pll
        && !main_pll_enable && !aux_pll_enable)
        else $error("bad state after sleep");
    sref_hold_a: assert property ($fell(self_refresh_req) |-> system_clocks_on && $past(system_clocks_on) && !bus_drain_req)
        else $error("refresh dropped early");
    stop_return_a: assert property ($rose(system_clocks_on) && !$past(system_reset) |-> clock_select_pll == $past(pll_select))
        else $error("clock selection not restored");
    lock_ref_a: assert property ($rose(main_pll_enable) && !system_clocks_on |-> !clock_select_pll && oscillator_enable)
        else $error("lock not on reference");
    cover property ($fell(core_power_enable));
    cover property ($rose(system_clocks_on) && !$past(system_reset));
    cover property ($fell(system_reset));
endmodule

bind spseq_sequencer spseq_checker i_checker (.*);

// [tb/spseq_partner.sv]
// Purpose: Bus and memory controller handshake model.
// Assumes: Same clock as the sequencer.
// Notes: dly sets how slowly both answer.
`timescale 1ns/1ps
module spseq_partner (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Requests
    input wire logic bus_drain_req,
    input wire logic self_refresh_req,
    input wire logic [3:0] dly,
    // Answers
    output logic bus_drain_ack,
    output logic self_refresh_ack
);
    logic [3:0] bus_cnt_reg;
    logic [3:0] mem_cnt_reg;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bus_cnt_reg <= 4'h0;
            mem_cnt_reg <= 4'h0;
        end else begin
            bus_cnt_reg <= !bus_drain_req ? 4'h0 : (bus_cnt_reg == dly ? dly : bus_cnt_reg + 4'h1);
            mem_cnt_reg <= !self_refresh_req ? 4'h0 : (mem_cnt_reg == dly ? dly : mem_cnt_reg + 4'h1);
        end
    end
    // Ack only after the pretended transfers drained
    assign bus_drain_ack = bus_drain_req && bus_cnt_reg == dly;
    assign self_refresh_ack = self_refresh_req && mem_cnt_reg == dly;
endmodule

// [tb/stop_sleep_power_sequencer_test.sv]
// Purpose: Directed stop, sleep and clock gating runs.
// Assumes: Short settle counts via parameter and writes.
// Notes: Waits are bounded.
`timescale 1ns/1ps
module stop_sleep_power_sequencer_test;
    logic clock = 1'b0, reset = 1'b1, stop_request = 1'b0, sleep_request = 1'b0;
    logic keep_oscillator_in_stop = 1'b0, sleep_exit_guard = 1'b0, crystal_in_use = 1'b1;
    logic main_pll_on = 1'b1, aux_pll_on = 1'b1, pll_select = 1'b1, crystal_settle_write = 1'b0;
    logic rtc_alarm = 1'b0, rtc_tick = 1'b0, battery_fault_input_n = 1'b1;
    logic [1:0] battery_fault_sleep_config = 2'h0;
    logic [15:0] main_pll_lock_count = 16'h0004, aux_pll_lock_count = 16'h0006, power_settle_count = 16'h0005;
    logic [15:0] crystal_settle_count = 16'h0004, external_interrupt_lines = 16'h0000;
    logic [31:0] block_clock_enable = 32'hffff_ffff, block_clock_gate;
    logic bus_drain_req, bus_drain_ack, self_refresh_req, self_refresh_ack, system_clocks_on;
    logic clock_select_pll, main_pll_enable, aux_pll_enable, oscillator_enable, core_power_enable;
    logic system_reset, sequencer_busy;
    logic [3:0] wake_cause, dly = 4'h0;
    int num_errors = 0, n_compared = 0;
    wire [5:0] mon = {system_reset, core_power_enable, system_clocks_on, self_refresh_req, bus_drain_req, sequencer_busy};
    spseq_sequencer #(.OSC_SETTLE_CYCLES(8)) i_dut (.*);
    spseq_partner i_partner (.*);
    always #2.5 clock = ~clock;
    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Bit index into mon: 0 busy, 1 drain, 2 refresh, 3 clocks, 4 power, 5 reset
    task automatic wait_bit(input int b, input logic v);
        for (int i = 0; i < 3000 && mon[b] !== v; i++) cyc(1);
        if (mon[b] !== v) begin
            num_errors++;
            $display("[ERR] %0t wait on bit %0d timed out", $time, b);
            report_and_stop();
        end
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock) crystal_settle_write <= 1'b1;
        @(posedge clock) crystal_settle_write <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            keep_oscillator_in_stop <= k[0];
            aux_pll_on <= !k[0];
            dly <= k[0] ? 4'h5 : 4'h0;
            pll_select <= !k[0];
            stop_request <= 1'b1;
            wait_bit(1, 1'b1);
            wait_bit(3, 1'b0);
            cyc(2);
            check({clock_select_pll, main_pll_enable, aux_pll_enable, oscillator_enable, block_clock_gate[0]},
                k[0] ? 32'h2 : 32'h0);
            @(posedge clock);
            if (k[0]) rtc_alarm <= 1'b1;
            else external_interrupt_lines <= 16'h8000;
            // Settle plus lock cycles must pass before clocks return
            cyc(k[0] ? 5 : 14);
            check(system_clocks_on, 1'b0);
            wait_bit(3, 1'b1);
            check({clock_select_pll, main_pll_enable, aux_pll_enable, oscillator_enable},
                k[0] ? 32'h5 : 32'hf);
            wait_bit(0, 1'b0);
            check({self_refresh_req, bus_drain_req, wake_cause}, k[0] ? 32'h2 : 32'h1);
            @(posedge clock);
            rtc_alarm <= 1'b0;
            external_interrupt_lines <= 16'h0000;
            cyc(20);
            check(bus_drain_req, 1'b0);
            @(posedge clock) stop_request <= 1'b0;
        end
        @(posedge clock) sleep_request <= 1'b1;
        wait_bit(4, 1'b0);
        check({system_reset, oscillator_enable, main_pll_enable, aux_pll_enable, system_clocks_on}, 32'h10);
        @(posedge clock) rtc_tick <= 1'b1;
        wait_bit(5, 1'b0);
        check({core_power_enable, system_clocks_on, clock_select_pll, main_pll_enable, aux_pll_enable}, 32'h18);
        wait_bit(0, 1'b0);
        check(wake_cause, 4'h4);
        @(posedge clock);
        rtc_tick <= 1'b0;
        sleep_request <= 1'b0;
        battery_fault_input_n <= 1'b0;
        cyc(20);
        check(sequencer_busy, 1'b0);
        @(posedge clock) {battery_fault_sleep_config, sleep_exit_guard} <= 3'h3;
        wait_bit(4, 1'b0);
        @(posedge clock) external_interrupt_lines <= 16'h0001;
        cyc(30);
        check(core_power_enable, 1'b0);
        @(posedge clock) battery_fault_input_n <= 1'b1;
        wait_bit(5, 1'b0);
        wait_bit(0, 1'b0);
        @(posedge clock) block_clock_enable <= 32'ha5a5_0f0f;
        cyc(1);
        check(block_clock_gate, 32'ha5a5_0f0f);
        report_and_stop();
    end
endmodule
